// ### host_model.sv
// host microcontroller model: drives the direct pins, resolves the clock pin
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic sys_clk,
    input wire logic [3:0] chan_cmd,
    input wire logic limp_cmd,
    input wire logic clk_pin_out,
    input wire logic clk_pin_oe,
    output logic [3:0] direct_channel_inputs,
    output logic fail_force_pin,
    output logic clk_pin_in
);
    ////////////////////////////////////////////////////////////////
    logic flip_ff = 1'b0; // filler level while nobody drives the pin
    // host pins move just after the edge, like a real port
    always @(posedge sys_clk) begin
        direct_channel_inputs <= chan_cmd;
        fail_force_pin <= limp_cmd;
        flip_ff <= ~flip_ff;
    end
    // a released pin toggles so that a stale high cannot pass for a report
    assign clk_pin_in = clk_pin_oe ? clk_pin_out : flip_ff;
endmodule
`default_nettype wire

// ### supply_and_fail_mode_control.sv
// supply state and operating mode supervisor with axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
module supply_and_fail_mode_control #(
    parameter int DGL_CYCLES = supply_mode_pkg::DGL_CYC,
    parameter int WD_SHORT_CYCLES = supply_mode_pkg::WD_SHORT_CYC,
    parameter int WD_LONG_CYCLES = supply_mode_pkg::WD_LONG_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic bat_ok,                 // battery above its reset level
    input wire logic vcc_ok,                 // logic supply above its reset level
    input wire logic wake,                   // wake condition
    input wire logic active_low_reset_pin_n, // reset pin
    input wire logic wake_by_reset,          // wake source was the reset pin
    input wire logic fail_force_pin,         // fail request pin
    input wire logic [3:0] direct_channel_inputs,
    input wire logic [3:0] pwm_channels,     // from pwm generator
    input wire logic [7:0] fault_flags,      // fault sources, sticky here
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe,
    output logic [3:0] high_side_channel_outputs,
    output logic external_switch_control_output,
    output logic deglitched_fail_request,
    output logic serial_read_enable,
    output logic [3:0] mode_state,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // internal reset: pin reset or both supplies gone
    logic power_off;
    // no synchroniser here: the clear must act even with the clock stopped
    assign power_off = !bat_ok && !vcc_ok;
    logic rst_n;
    // both supplies down resets every register asynchronously
    assign rst_n = arst_n && !power_off;

    ////////////////////////////////////////////////////////////////////////
    // whole state in one struct
    typedef struct packed {
        logic [2:0] bat_sy;        // battery synchroniser
        logic [2:0] vcc_sy;        // logic supply synchroniser
        logic [2:0] wake_sy;
        logic [2:0] rst_sy;
        logic [2:0] fail_sy;
        logic bat_q; // agreed battery level
        logic vcc_q; // agreed logic supply level
        logic wake_q; // agreed wake level
        logic rst_q; // agreed reset pin level
        logic fail_q; // agreed fail pin level
        logic [31:0] dgl_cnt;      // deglitch counter
        logic fail_req;            // deglitched fail request
        logic [31:0] wd_cnt;       // watchdog counter
        logic wd_err;              // sticky watchdog error
        logic wd_last;             // last toggle bit
        logic [31:0] ctrl;
        logic [7:0] faults;        // sticky fault flags
        supply_mode_pkg::mode_t mode;
        logic [3:0] hs_out;
        logic ext_out;
        logic aw_got; // write address held
        logic w_got; // write data held
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    // registered state and its next value
    state_t st_ff, nxt_st;
    logic [7:0] rd_addr;
    logic wr_fire;
    logic sel_wd;

    assign rd_addr = s_axi_araddr[7:0];
    assign sel_wd = st_ff.ctrl[supply_mode_pkg::CTRL_WDSEL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // next state logic
    always_comb begin
        nxt_st = st_ff;
        wr_fire = 1'b0;
        // three stage synchronisers; level changes when stages 2 and 3 agree
        nxt_st.bat_sy = {st_ff.bat_sy[1:0], bat_ok};
        nxt_st.vcc_sy = {st_ff.vcc_sy[1:0], vcc_ok};
        nxt_st.wake_sy = {st_ff.wake_sy[1:0], wake};
        nxt_st.rst_sy = {st_ff.rst_sy[1:0], active_low_reset_pin_n};
        nxt_st.fail_sy = {st_ff.fail_sy[1:0], fail_force_pin};
        if (st_ff.bat_sy[1] == st_ff.bat_sy[2]) begin
            nxt_st.bat_q = st_ff.bat_sy[2];
        end
        if (st_ff.vcc_sy[1] == st_ff.vcc_sy[2]) begin
            nxt_st.vcc_q = st_ff.vcc_sy[2];
        end
        if (st_ff.wake_sy[1] == st_ff.wake_sy[2]) begin
            nxt_st.wake_q = st_ff.wake_sy[2];
        end
        if (st_ff.rst_sy[1] == st_ff.rst_sy[2]) begin
            nxt_st.rst_q = st_ff.rst_sy[2];
        end
        if (st_ff.fail_sy[1] == st_ff.fail_sy[2]) begin
            nxt_st.fail_q = st_ff.fail_sy[2];
        end
        // symmetric deglitch: level must hold the full time to flip
        if (st_ff.fail_q == st_ff.fail_req) begin
            nxt_st.dgl_cnt = 32'h0000_0000;
        end else if (st_ff.dgl_cnt >= 32'(DGL_CYCLES - 1)) begin
            nxt_st.fail_req = st_ff.fail_q;
            nxt_st.dgl_cnt = 32'h0000_0000;
        end else begin
            nxt_st.dgl_cnt = st_ff.dgl_cnt + 32'h0000_0001;
        end
        // sticky faults, visible through the fault register read path
        nxt_st.faults = st_ff.faults | fault_flags;

        // axi write channel capture, either order
        if (s_axi_awvalid && !st_ff.aw_got) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !st_ff.w_got) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        // both halves held: execute once, answer on the next edge
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            wr_fire = 1'b1;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = 2'h0;
            unique case (st_ff.aw_addr)
                supply_mode_pkg::CTRL_OFS: begin
                    for (int b = 0; b < 4; b++) begin
                        if (st_ff.w_strb[b]) begin
                            nxt_st.ctrl[b*8 +: 8] = st_ff.w_data[b*8 +: 8];
                        end
                    end
                end
                supply_mode_pkg::FAULT_OFS: begin
                    // write one to clear; a new fault the same cycle wins
                    nxt_st.faults = (st_ff.faults & ~st_ff.w_data[7:0]) | fault_flags;
                end
                supply_mode_pkg::WDOG_OFS: begin
                    // a frame that fails to toggle the bit is an error
                    if (st_ff.w_data[0] == st_ff.wd_last) begin
                        nxt_st.wd_err = 1'b1;
                    end
                    nxt_st.wd_last = st_ff.w_data[0];
                    nxt_st.wd_cnt = 32'h0000_0000;
                end
                supply_mode_pkg::STATUS_OFS: begin
                    nxt_st.bresp = 2'h0;
                end
                default: begin
                    nxt_st.bresp = 2'h2;
                end
            endcase
        end
        // response stands until the master takes it
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // software resume request leaves fail mode; it sits ahead of the error
        // sources so that a timeout in the same cycle still wins
        if (wr_fire && st_ff.aw_addr == supply_mode_pkg::CTRL_OFS
            && st_ff.w_data[supply_mode_pkg::CTRL_RESUME_BIT] && !st_ff.fail_req && st_ff.vcc_q) begin
            nxt_st.wd_err = 1'b0;
            nxt_st.wd_cnt = 32'h0000_0000;
        end
        // watchdog timeout, period picked by control bit
        // the timer only runs in normal mode; sleep and fail hold it at zero
        if (!wr_fire || st_ff.aw_addr != supply_mode_pkg::WDOG_OFS) begin
            if (st_ff.mode == supply_mode_pkg::MODE_NORMAL) begin
                if (st_ff.wd_cnt >= 32'(sel_wd ? WD_LONG_CYCLES - 1 : WD_SHORT_CYCLES - 1)) begin
                    nxt_st.wd_err = 1'b1;
                end else begin
                    nxt_st.wd_cnt = st_ff.wd_cnt + 32'h0000_0001;
                end
            end else begin
                nxt_st.wd_cnt = 32'h0000_0000;
            end
        end
        // logic supply lost with battery present: same as a timeout
        if (st_ff.bat_q && !st_ff.vcc_q) begin
            nxt_st.wd_err = 1'b1;
        end

        // axi read channel
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = 2'h0;
            nxt_st.rdata = 32'h0000_0000;
            // serial output stage unpowered: refuse the read
            if (!st_ff.vcc_q) begin
                nxt_st.rresp = 2'h2;
            end else begin
                // unmapped offsets answer with an error
                unique case (rd_addr)
                    supply_mode_pkg::CTRL_OFS: nxt_st.rdata = st_ff.ctrl;
                    supply_mode_pkg::STATUS_OFS: begin
                        nxt_st.rdata[supply_mode_pkg::ST_FAILIN_BIT] = st_ff.fail_q;
                        nxt_st.rdata[supply_mode_pkg::ST_WDERR_BIT] = st_ff.wd_err;
                        nxt_st.rdata[supply_mode_pkg::ST_MODE_LSB +: 4] = st_ff.mode;
                    end
                    supply_mode_pkg::FAULT_OFS: nxt_st.rdata[7:0] = st_ff.faults;
                    supply_mode_pkg::WDOG_OFS: nxt_st.rdata[0] = st_ff.wd_last;
                    default: nxt_st.rresp = 2'h2;
                endcase
            end
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // mode selection in priority order
        if (!st_ff.bat_q && !st_ff.vcc_q) begin
            nxt_st.mode = supply_mode_pkg::MODE_OFF;
        end else if (!st_ff.wake_q) begin
            nxt_st.mode = supply_mode_pkg::MODE_SLEEP;
        end else if (st_ff.fail_req || st_ff.wd_err) begin
            nxt_st.mode = supply_mode_pkg::MODE_FAIL;
        end else begin
            nxt_st.mode = supply_mode_pkg::MODE_NORMAL;
        end

        // channel drive by mode; battery loss cuts the channels
        unique case (st_ff.mode)
            supply_mode_pkg::MODE_FAIL: nxt_st.hs_out = direct_channel_inputs;
            supply_mode_pkg::MODE_NORMAL: nxt_st.hs_out = pwm_channels;
            supply_mode_pkg::MODE_OFF, supply_mode_pkg::MODE_SLEEP: nxt_st.hs_out = 4'h0;
            default: nxt_st.hs_out = 4'h0;
        endcase
        if (!st_ff.bat_q) begin
            nxt_st.hs_out = 4'h0;
        end
        // external switch keeps its config during battery loss
        nxt_st.ext_out = st_ff.ctrl[supply_mode_pkg::CTRL_EXT_BIT] && st_ff.vcc_q
            && (st_ff.mode == supply_mode_pkg::MODE_NORMAL || !st_ff.bat_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, cleared on pin reset or power off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            // mode and control carry their own reset codes
            st_ff.mode <= supply_mode_pkg::MODE_OFF;
            st_ff.ctrl <= supply_mode_pkg::CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // the pin is only driven here; reading it back is left to the host
    // reset pin low: clock pin reports wake, driven only when awake on battery
    assign clk_pin_oe = !st_ff.rst_q && st_ff.wake_q && !wake_by_reset && st_ff.bat_q;
    assign clk_pin_out = clk_pin_oe;
    // data outputs straight from flip-flops
    assign high_side_channel_outputs = st_ff.hs_out;
    assign external_switch_control_output = st_ff.ext_out;
    assign deglitched_fail_request = st_ff.fail_req;
    assign serial_read_enable = st_ff.vcc_q;
    assign mode_state = st_ff.mode;
    // a channel is ready while its holding slot is empty
    assign s_axi_awready = !st_ff.aw_got;
    assign s_axi_wready = !st_ff.w_got;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    sequence fail_held;
        st_ff.fail_req && st_ff.wake_q && (st_ff.bat_q || st_ff.vcc_q);
    endsequence

    // sleep follows a low wake level within one edge
    a_sleep_when_asleep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!st_ff.wake_q && (st_ff.bat_q || st_ff.vcc_q)) |=> st_ff.mode == supply_mode_pkg::MODE_SLEEP)
        else $error("not asleep with wake low");
    // no read data without the logic supply
    a_read_no_vcc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && !st_ff.vcc_q) |=> s_axi_rresp == 2'h2)
        else $error("read served without logic supply");
    // every wake report condition drives the pin high
    a_clk_pin_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!st_ff.rst_q && st_ff.wake_q && !wake_by_reset && st_ff.bat_q) |-> clk_pin_oe && clk_pin_out)
        else $error("clock pin wake report missing");
    // sleep, reset wake or battery loss release the pin
    a_clk_pin_input: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!st_ff.wake_q || wake_by_reset || !st_ff.bat_q) |-> !clk_pin_oe)
        else $error("clock pin driven in sleep");
    // battery loss cuts the channels on the next edge
    a_channels_batloss: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !st_ff.bat_q |=> high_side_channel_outputs == 4'h0)
        else $error("channel on without battery");
    // a held fail request wins over normal mode
    a_fail_mode_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fail_held |=> st_ff.mode == supply_mode_pkg::MODE_FAIL)
        else $error("fail request ignored");
    // fail mode channels track the direct inputs
    a_fail_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff.mode == supply_mode_pkg::MODE_FAIL && st_ff.bat_q && $stable(direct_channel_inputs))
        |=> high_side_channel_outputs == $past(direct_channel_inputs))
        else $error("fail outputs do not follow inputs");
    // logic supply loss raises the watchdog error
    a_vcc_loss_wd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff.bat_q && !st_ff.vcc_q) |=> st_ff.wd_err)
        else $error("logic supply loss not a timeout");
    // the request only rises after a steady input; the input may drop again at the rise
    a_dgl_glitch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(st_ff.fail_req) |-> $past(st_ff.fail_q) && $past(st_ff.fail_q, 2))
        else $error("fail request without stable input");
endmodule
`default_nettype wire

// ### supply_and_fail_mode_control_tb.sv
// self-checking bench for the supply and fail mode supervisor
`timescale 1ns/100ps
`default_nettype none
module supply_and_fail_mode_control_tb;
    ////////////////////////////////////////////////////////////////
    localparam logic [7:0] CTL = supply_mode_pkg::CTRL_OFS;
    localparam logic [7:0] STA = supply_mode_pkg::STATUS_OFS;
    localparam logic [7:0] FLT = supply_mode_pkg::FAULT_OFS;
    localparam logic [7:0] WDG = supply_mode_pkg::WDOG_OFS;
    localparam logic [3:0] OFF = supply_mode_pkg::MODE_OFF;
    localparam logic [3:0] SLP = supply_mode_pkg::MODE_SLEEP;
    localparam logic [3:0] FAIL = supply_mode_pkg::MODE_FAIL;
    localparam logic [3:0] NRM = supply_mode_pkg::MODE_NORMAL;
    logic sys_clk, arst_n = 1'b0, bat_ok = 1'b1, vcc_ok = 1'b1, wake = 1'b1;
    logic wake_by_reset = 1'b0, active_low_reset_pin_n = 1'b1, limp_cmd = 1'b0;
    logic [3:0] chan_cmd = 4'h0, pwm_channels = 4'h0, direct_channel_inputs, mode_state, high_side_channel_outputs;
    logic [7:0] fault_flags = 8'h00;
    logic fail_force_pin, clk_pin_in, clk_pin_out, clk_pin_oe, external_switch_control_output;
    logic deglitched_fail_request, serial_read_enable;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic wd_bit = 1'b0; // last watchdog bit written
    int fail_count = 0, checks = 0;
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // short counts keep the run brief: deglitch 8, watchdog 50 and 100 cycles
    supply_and_fail_mode_control #(.DGL_CYCLES(8), .WD_SHORT_CYCLES(50), .WD_LONG_CYCLES(100))
    supply_and_fail_mode_control_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .bat_ok(bat_ok), .vcc_ok(vcc_ok), .wake(wake),
        .active_low_reset_pin_n(active_low_reset_pin_n), .wake_by_reset(wake_by_reset),
        .fail_force_pin(fail_force_pin), .direct_channel_inputs(direct_channel_inputs),
        .pwm_channels(pwm_channels), .fault_flags(fault_flags), .clk_pin_in(clk_pin_in),
        .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .high_side_channel_outputs(high_side_channel_outputs),
        .external_switch_control_output(external_switch_control_output),
        .deglitched_fail_request(deglitched_fail_request), .serial_read_enable(serial_read_enable),
        .mode_state(mode_state), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    host_model host_model_inst (.sys_clk(sys_clk), .chan_cmd(chan_cmd), .limp_cmd(limp_cmd),
        .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .direct_channel_inputs(direct_channel_inputs),
        .fail_force_pin(fail_force_pin), .clk_pin_in(clk_pin_in));
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    // a used-up wait counts as a mismatch and closes the run
    task automatic hang();
        fail_count++;
        print_verdict();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wait_mode(input logic [3:0] m);
        int n;
        for (n = 0; n < 300 && mode_state !== m; n++) @(posedge sys_clk);
        if (n == 300) hang();
        checks++;
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang();
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang();
    endtask
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        axi_wr(a, d, rsp);
        chk(rsp, e);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_rd(a, rd, rsp);
        chk(rsp, er);
        chk(rd, e);
    endtask
    // the watchdog bit must change on every write
    task automatic kick();
        wd_bit = ~wd_bit;
        wchk(WDG, {31'h0, wd_bit}, 2'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_boot();
        wait_mode(NRM);
        wchk(CTL, 32'h2, 2'h0);
        kick();
        rchk(STA, 32'h80, 2'h0);
        rchk(8'h10, 32'h0, 2'h2);
        wchk(8'h14, 32'h1, 2'h2);
        pwm_channels <= 4'h5;
        cyc(4);
        chk(high_side_channel_outputs, 4'h5);
        fault_flags <= 8'h81;
        cyc(1);
        fault_flags <= 8'h00;
        rchk(FLT, 32'h81, 2'h0);
        wchk(FLT, 32'h1, 2'h0);
        rchk(FLT, 32'h80, 2'h0);
        kick();
    endtask
    // a short pulse is swallowed, a held level forces direct control
    task automatic t_fail();
        limp_cmd <= 1'b1;
        cyc(3);
        limp_cmd <= 1'b0;
        cyc(20);
        chk(mode_state, NRM);
        chk(deglitched_fail_request, 1'b0);
        kick();
        chan_cmd <= 4'h9;
        limp_cmd <= 1'b1;
        wait_mode(FAIL);
        chk(deglitched_fail_request, 1'b1);
        cyc(4);
        chk(high_side_channel_outputs, 4'h9);
        rchk(STA, 32'h41, 2'h0);
        chan_cmd <= 4'h6;
        cyc(4);
        chk(high_side_channel_outputs, 4'h6);
        limp_cmd <= 1'b0;
        cyc(20);
        wchk(CTL, 32'h6, 2'h0);
        wait_mode(NRM);
        kick();
    endtask
    // repeated bit, then silence: both end in fail mode
    task automatic t_wdog();
        wchk(WDG, {31'h0, wd_bit}, 2'h0);
        wait_mode(FAIL);
        rchk(STA, 32'h42, 2'h0);
        wchk(CTL, 32'h6, 2'h0);
        wait_mode(NRM);
        kick();
        cyc(80);
        chk(mode_state, NRM);
        wait_mode(FAIL);
        wchk(CTL, 32'h6, 2'h0);
        wait_mode(NRM);
        kick();
    endtask
    // wake report on the clock pin, then battery loss with logic supply kept
    task automatic t_bat();
        wchk(CTL, 32'h3, 2'h0);
        pwm_channels <= 4'hf;
        active_low_reset_pin_n <= 1'b0;
        cyc(8);
        chk(external_switch_control_output, 1'b1);
        chk({clk_pin_oe, clk_pin_out, clk_pin_in}, 3'h7);
        wake_by_reset <= 1'b1;
        cyc(2);
        chk(clk_pin_oe, 1'b0);
        wake_by_reset <= 1'b0;
        bat_ok <= 1'b0;
        cyc(8);
        chk(high_side_channel_outputs, 4'h0);
        chk(external_switch_control_output, 1'b1);
        chk(clk_pin_oe, 1'b0);
        rchk(FLT, 32'h80, 2'h0);
        rchk(CTL, 32'h3, 2'h0);
        bat_ok <= 1'b1;
        active_low_reset_pin_n <= 1'b1;
        wait_mode(NRM);
        kick();
    endtask
    task automatic t_vcc();
        vcc_ok <= 1'b0;
        wait_mode(FAIL);
        chk(serial_read_enable, 1'b0);
        rchk(STA, 32'h0, 2'h2);
        vcc_ok <= 1'b1;
        cyc(6);
        chk(serial_read_enable, 1'b1);
        wchk(CTL, 32'h6, 2'h0);
        wait_mode(NRM);
        kick();
    endtask
    // sleep outranks a forced fail; losing both supplies clears everything
    task automatic t_off();
        limp_cmd <= 1'b1;
        wake <= 1'b0;
        active_low_reset_pin_n <= 1'b0;
        wait_mode(SLP);
        cyc(20);
        chk(mode_state, SLP);
        chk(clk_pin_oe, 1'b0);
        bat_ok <= 1'b0;
        vcc_ok <= 1'b0;
        cyc(2);
        chk({mode_state, high_side_channel_outputs, external_switch_control_output}, 9'h020);
        {bat_ok, vcc_ok, wake, active_low_reset_pin_n, limp_cmd} <= 5'h1e;
        wd_bit = 1'b0;
        wait_mode(NRM);
        kick();
        rchk(FLT, 32'h0, 2'h0);
        rchk(CTL, 32'h0, 2'h0);
        // cleared control means the short period: timeout near 50 cycles, not 100
        cyc(30);
        chk(mode_state, NRM);
        cyc(20);
        chk(mode_state, FAIL);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge sys_clk);
        chk({mode_state, clk_pin_oe}, {OFF, 1'b0});
        arst_n <= 1'b1;
        t_boot();
        t_fail();
        t_wdog();
        t_bat();
        t_vcc();
        t_off();
        print_verdict();
    end
endmodule
`default_nettype wire

// ### supply_mode_pkg.sv
// constants and types shared by the supply and fail mode supervisor
// Summary of operation
// - operate only while awake, else sleep
// - serial reads blocked without logic supply
// - clock pin reports wake while reset low
// - awake and reset low drives pin high
// - sleep or reset wake leaves pin input
// - both supplies lost clears all, outputs off
// - battery lost keeps state, channels off
// - external switch follows config on battery loss
// - wake during battery loss not reported
// - logic supply lost acts as watchdog timeout
// - normal mode channels follow pwm generator
// - faults reported through serial status
// - high fail input forces fail mode
// - fail mode channels follow direct inputs
// - fail forcing works without logic supply
// - fail input level readable in status
// - fail input deglitched for 200 us
// - watchdog toggle miss or timeout means fail
`default_nettype none
package supply_mode_pkg;
    localparam int CLK_MHZ = 200;
    localparam int DGL_US = 200;
    localparam int DGL_CYC = DGL_US * CLK_MHZ;
    localparam int WD_SHORT_MS = 32;
    localparam int WD_LONG_MS = 128;
    localparam int WD_SHORT_CYC = WD_SHORT_MS * 1000 * CLK_MHZ;
    localparam int WD_LONG_CYC = WD_LONG_MS * 1000 * CLK_MHZ;
    localparam int NCH = 4;
    // axi register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] FAULT_OFS = 8'h08;
    localparam logic [7:0] WDOG_OFS = 8'h0c;
    // control field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_WDSEL_BIT = 1;
    localparam int CTRL_RESUME_BIT = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // status field positions
    localparam int ST_FAILIN_BIT = 0;
    localparam int ST_WDERR_BIT = 1;
    localparam int ST_MODE_LSB = 4;
    typedef enum logic [3:0] {
        MODE_OFF = 4'h1,
        MODE_SLEEP = 4'h2,
        MODE_FAIL = 4'h4,
        MODE_NORMAL = 4'h8
    } mode_t;
endpackage
`default_nettype wire
